// *** logic/host_serial_pkg.sv ***
// constants and types shared by the host serial port logic
`default_nettype none
package host_serial_pkg;
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int DEFAULT_BAUD = 9600;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'(CORE_CLK_HZ / DEFAULT_BAUD);
  localparam logic [11:0] RX_BUF_BYTES = 12'h834;
  localparam logic [11:0] FT_MAX = 12'h823;
  localparam logic [11:0] FT_DEFAULT = 12'h7F3;
  localparam logic [11:0] FT_HYST = 12'h011;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] PIN_FN_SPI = 3'h1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] API_FMT_SPI = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  typedef enum logic [2:0] {
    SEL_INIT = 3'h0,
    SEL_BOTH = 3'h1,
    SEL_UART = 3'h2,
    SEL_SPI = 3'h3,
    SEL_OFF = 3'h4
  } port_sel_e;
  typedef enum logic [2:0] {
    U_IDLE = 3'h0,
    U_START = 3'h1,
    U_DATA = 3'h2,
    U_PAR = 3'h3,
    U_STOP = 3'h4
  } uart_st_e;
endpackage
`default_nettype wire

// *** logic/host_serial_port_select.sv ***
// host serial port: uart, spi slave, port selection and flow control
`timescale 1ns/100ps
`default_nettype none
module host_serial_port_select (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_clk_i,
  input wire logic slave_select_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic attention_out_n_o,
  input wire logic uart_rx_i,
  input wire logic spi_force_strap_pin_i,
  output logic spi_force_strap_pin_o,
  output logic spi_force_strap_pin_oe_o,
  input wire logic host_ready_n_i,
  output logic module_ready_n_o,
  input wire logic [15:0] baud_setting_i,
  input wire logic [1:0] parity_setting_i,
  input wire logic stop_bits_setting_i,
  input wire logic uart_enable_cfg_i,
  input wire logic spi_enable_cfg_i,
  input wire logic host_ready_flow_enable_i,
  input wire logic module_ready_flow_enable_i,
  input wire logic [11:0] flow_stop_threshold_i,
  input wire logic [1:0] api_format_setting_i,
  output logic [1:0] api_format_setting_o,
  input wire logic [2:0] pin_config_one_i,
  input wire logic [2:0] pin_config_two_i,
  input wire logic [2:0] pin_config_three_i,
  input wire logic [2:0] pin_config_four_i,
  input wire logic [2:0] pin_config_p_two_i,
  output logic [2:0] pin_config_one_o,
  output logic [2:0] pin_config_two_o,
  output logic [2:0] pin_config_three_o,
  output logic [2:0] pin_config_four_o,
  output logic [2:0] pin_config_p_two_o,
  input wire logic save_config_i,
  output logic store_forced_o,
  output logic uart_selected_o,
  output logic spi_selected_o,
  output logic command_mode_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_drop_o,
  input wire logic rx_take_i,
  output logic [11:0] rx_level_o,
  output logic parity_error_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic status_frame_o,
  input wire logic pkt_offer_i,
  input wire logic [11:0] pkt_len_i,
  input wire logic [11:0] tx_space_i,
  input wire logic sys_buf_full_i,
  output logic pkt_accept_o,
  output logic pkt_drop_o
);
  import host_serial_pkg::*;

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] m);
    par_of = (m == PAR_EVEN) ? ^d : (m == PAR_ODD) ? ~^d : (m != PAR_NONE);
  endfunction

  // ****************************************
  // pin synchronisers and port selection
  // ****************************************
  logic [2:0] pin_meta, pin_sync;
  logic [1:0] settle;
  port_sel_e sel, next_sel, cfg_sel;
  logic forced, status_pending, default_uart, command_mode;
  logic urx_done, spi_byte, spi_take, utx_take;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      pin_meta <= {uart_rx_i, spi_force_strap_pin_i, host_ready_n_i};
      pin_sync <= pin_meta;
    end
  end

  wire din_low = ~pin_sync[2];
  wire dout_low = ~pin_sync[1];
  wire rts_high = pin_sync[0];
  wire settled = (settle == STRAP_SETTLE);
  wire deciding = (sel == SEL_INIT) && settled;

  assign cfg_sel = (uart_enable_cfg_i && spi_enable_cfg_i) ? SEL_BOTH :
                   uart_enable_cfg_i ? SEL_UART :
                   spi_enable_cfg_i ? SEL_SPI : SEL_OFF;

  always_comb begin
    next_sel = sel;
    unique case (sel)
      SEL_INIT: if (settled) begin
        next_sel = din_low ? SEL_UART : dout_low ? SEL_SPI : cfg_sel;
      end
      SEL_BOTH: if (urx_done) begin
        next_sel = SEL_UART;
      end else if (spi_byte) begin
        next_sel = SEL_SPI;
      end
      SEL_UART, SEL_SPI, SEL_OFF: next_sel = sel;
      default: next_sel = SEL_INIT;
    endcase
  end

  // straps are caught after release, not under reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle <= 2'h0;
      sel <= SEL_INIT;
      forced <= 1'b0;
      default_uart <= 1'b0;
      command_mode <= 1'b0;
      status_pending <= 1'b0;
      status_frame_o <= 1'b0;
      store_forced_o <= 1'b0;
    end else begin
      settle <= settled ? settle : settle + 2'h1;
      sel <= next_sel;
      status_frame_o <= deciding && !din_low && dout_low;
      store_forced_o <= save_config_i && forced;
      if (deciding) begin
        default_uart <= din_low;
        command_mode <= din_low;
        forced <= !din_low && dout_low;
      end
      if (deciding && !din_low && dout_low) begin
        status_pending <= 1'b1;
      end else if (spi_take) begin
        status_pending <= 1'b0;
      end
    end
  end

  assign command_mode_o = command_mode;
  assign uart_selected_o = (sel == SEL_UART);
  assign spi_selected_o = (sel == SEL_SPI);
  assign api_format_setting_o = spi_selected_o ? API_FMT_SPI : api_format_setting_i;
  // forced values live only until reset; save asks upstream to store them
  assign pin_config_one_o = (forced && pin_config_one_i == 3'h0) ? PIN_FN_SPI
                            : pin_config_one_i;
  assign pin_config_two_o = forced ? PIN_FN_SPI : pin_config_two_i;
  assign pin_config_three_o = forced ? PIN_FN_SPI : pin_config_three_i;
  assign pin_config_four_o = forced ? PIN_FN_SPI : pin_config_four_i;
  assign pin_config_p_two_o = forced ? PIN_FN_SPI : pin_config_p_two_i;

  // ****************************************
  // uart framing
  // ****************************************
  wire uart_on = (sel == SEL_UART) || (sel == SEL_BOTH);
  wire [15:0] div = default_uart ? BAUD_DIV_DEFAULT : baud_setting_i;
  wire [1:0] par = default_uart ? PAR_NONE : parity_setting_i;
  wire two_stop = !default_uart && stop_bits_setting_i;
  wire [15:0] div_m1 = div - 16'h1;
  uart_st_e urx, utx;
  logic [15:0] rcnt, tcnt;
  logic [2:0] rbit, tbit;
  logic [7:0] rsh, tsh;
  logic txd, tpar, tstop;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      urx <= U_IDLE;
      rcnt <= 16'h0;
      rbit <= 3'h0;
      rsh <= 8'h0;
      urx_done <= 1'b0;
      parity_error_o <= 1'b0;
    end else begin
      urx_done <= 1'b0;
      rcnt <= (rcnt == 16'h0) ? div_m1 : rcnt - 16'h1;
      unique case (urx)
        U_IDLE: if (uart_on && din_low) begin
          urx <= U_START;
          rcnt <= {1'b0, div[15:1]};
        end
        U_START: if (rcnt == 16'h0) begin
          urx <= din_low ? U_DATA : U_IDLE;
          rbit <= 3'h0;
        end
        U_DATA: if (rcnt == 16'h0) begin
          rsh <= {~din_low, rsh[7:1]};
          rbit <= rbit + 3'h1;
          if (rbit == LAST_BIT) urx <= (par != PAR_NONE) ? U_PAR : U_STOP;
        end
        U_PAR: if (rcnt == 16'h0) begin
          parity_error_o <= (~din_low != par_of(rsh, par));
          urx <= U_STOP;
        end
        U_STOP: if (rcnt == 16'h0) begin
          urx <= U_IDLE;
          urx_done <= !din_low;
        end
        default: urx <= U_IDLE;
      endcase
    end
  end

  // host-ready is obeyed per character, never mid-frame
  wire rts_block = host_ready_flow_enable_i && rts_high;
  assign utx_take = uart_on && (utx == U_IDLE) && !rts_block && tx_valid_i;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      utx <= U_IDLE;
      tcnt <= 16'h0;
      tbit <= 3'h0;
      tsh <= 8'h0;
      txd <= 1'b1;
      tpar <= 1'b0;
      tstop <= 1'b0;
    end else begin
      tcnt <= (tcnt == 16'h0) ? div_m1 : tcnt - 16'h1;
      unique case (utx)
        U_IDLE: if (utx_take) begin
          utx <= U_START;
          tsh <= tx_data_i;
          tpar <= par_of(tx_data_i, par);
          txd <= 1'b0;
          tcnt <= div_m1;
        end
        U_START: if (tcnt == 16'h0) begin
          utx <= U_DATA;
          txd <= tsh[0];
          tsh <= {1'b0, tsh[7:1]};
          tbit <= 3'h0;
        end
        U_DATA: if (tcnt == 16'h0) begin
          tbit <= tbit + 3'h1;
          txd <= (tbit == LAST_BIT) ? ((par == PAR_NONE) || tpar) : tsh[0];
          tsh <= {1'b0, tsh[7:1]};
          tstop <= two_stop;
          if (tbit == LAST_BIT) utx <= (par != PAR_NONE) ? U_PAR : U_STOP;
        end
        U_PAR: if (tcnt == 16'h0) begin
          utx <= U_STOP;
          txd <= 1'b1;
        end
        U_STOP: if (tcnt == 16'h0) begin
          tstop <= 1'b0;
          if (!tstop) utx <= U_IDLE;
        end
        default: utx <= U_IDLE;
      endcase
    end
  end

  assign spi_force_strap_pin_o = txd;
  assign spi_force_strap_pin_oe_o = uart_on; // pin stays free for the strap until uart or both ports are selected, and for good under spi or off

  // ****************************************
  // spi slave, link clock domain
  // ****************************************
  wire frame_b = rst_b_i && !slave_select_n_i;
  logic [2:0] sbit;
  logic [6:0] srx;
  logic [7:0] rx_hold, ssh, hold;
  logic rx_tgl, req, req_m, req_s, ack, loaded;
  logic rt_m, rt_s, rt_d, ack_m, ack_s;

  // bit count restarts with every select, so a cut byte cannot skew the next
  always_ff @(posedge spi_clk_i or negedge frame_b) begin
    if (!frame_b) begin
      sbit <= 3'h0;
      srx <= 7'h0;
    end else begin
      sbit <= sbit + 3'h1;
      srx <= {srx[5:0], spi_mosi_i};
    end
  end

  always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_hold <= 8'h0;
      rx_tgl <= 1'b0;
    end else if (!slave_select_n_i && sbit == LAST_BIT) begin
      rx_hold <= {srx, spi_mosi_i};
      rx_tgl <= ~rx_tgl;
    end
  end

  // next byte is committed at the byte boundary on the falling edge
  always_ff @(negedge spi_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      ack <= 1'b0;
      loaded <= 1'b0;
      ssh <= 8'h0;
    end else begin
      req_m <= req;
      req_s <= req_m;
      if (sbit != 3'h0) begin
        ssh <= {ssh[6:0], ssh[0]};
      end else if (loaded) begin
        // ack only once the byte has gone out, so attention holds till then
        ssh <= {8{ssh[7]}};
        ack <= ~ack;
        loaded <= 1'b0;
      end else if (req_s != ack) begin
        ssh <= hold;
        loaded <= 1'b1;
      end else begin
        ssh <= {8{ssh[7]}};
      end
    end
  end

  assign spi_miso_o = ssh[7];
  assign spi_miso_oe_o = (sel == SEL_SPI) && !slave_select_n_i;

  // ****************************************
  // core side of the crossing
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rt_m <= 1'b0;
      rt_s <= 1'b0;
      rt_d <= 1'b0;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      req <= 1'b0;
      hold <= 8'h0;
    end else begin
      rt_m <= rx_tgl;
      rt_s <= rt_m;
      rt_d <= rt_s;
      ack_m <= ack;
      ack_s <= ack_m;
      if (spi_take) begin
        hold <= tx_data_i;
        req <= ~req;
      end
    end
  end

  wire spi_in_on = (sel == SEL_SPI) || (sel == SEL_BOTH);
  wire spi_busy = (req != ack_s);
  assign spi_byte = (rt_s ^ rt_d) && spi_in_on;
  assign spi_take = (sel == SEL_SPI) && tx_valid_i && !spi_busy;
  assign tx_ready_o = (sel == SEL_SPI) ? !spi_busy : utx_take;
  assign attention_out_n_o = !((sel == SEL_SPI)
                               && (tx_valid_i || status_pending || spi_busy));

  // ****************************************
  // receive buffer accounting and flow control
  // ****************************************
  logic [11:0] level;
  logic cts_stop;
  wire in_byte = (urx_done && uart_on) || spi_byte;
  wire buf_full = (level >= RX_BUF_BYTES);
  wire accept = in_byte && !buf_full;
  wire take = rx_take_i && (level != 12'h0);
  wire [11:0] next_level = level + {11'h0, accept} - {11'h0, take};
  wire [11:0] ft_eff = (flow_stop_threshold_i > FT_MAX) ? FT_MAX : flow_stop_threshold_i;
  wire [11:0] ft_low = (ft_eff < FT_HYST) ? 12'h0 : ft_eff - FT_HYST;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level <= 12'h0;
      cts_stop <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_drop_o <= 1'b0;
      rx_data_o <= 8'h0;
      pkt_accept_o <= 1'b0;
      pkt_drop_o <= 1'b0;
    end else begin
      level <= next_level;
      rx_valid_o <= accept;
      rx_drop_o <= in_byte && buf_full;
      rx_data_o <= urx_done ? rsh : rx_hold;
      if (level >= ft_eff) cts_stop <= 1'b1;
      else if (level <= ft_low) cts_stop <= 1'b0;
      pkt_drop_o <= pkt_offer_i && (pkt_len_i > tx_space_i) && sys_buf_full_i;
      pkt_accept_o <= pkt_offer_i && !((pkt_len_i > tx_space_i) && sys_buf_full_i);
    end
  end

  assign rx_level_o = level;
  assign module_ready_n_o = module_ready_flow_enable_i && cts_stop;

  // ****************************************
  // checks
  // ****************************************
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_din_strap;
    deciding && din_low;
  endsequence
  sequence s_dout_strap;
    deciding && !din_low && dout_low;
  endsequence

  a_din_strap_uart: assert property (s_din_strap |=> uart_selected_o && command_mode_o
    && div == BAUD_DIV_DEFAULT) else $error("din strap did not force uart");
  a_dout_strap_spi: assert property (s_dout_strap |=> spi_selected_o
    && status_frame_o && !attention_out_n_o) else $error("spi strap failed");
  a_port_lock: assert property ((sel == SEL_UART || sel == SEL_SPI) |=> $stable(sel))
    else $error("locked port changed");
  a_overflow_drop: assert property (in_byte && buf_full |=> rx_drop_o && !rx_valid_o
    && level == $past(level) - {11'h0, $past(take)}) else $error("overflow byte kept");
  a_flow_stop_set: assert property (level >= ft_eff |=> cts_stop)
    else $error("stop not signalled");
  a_flow_resume: assert property ($fell(cts_stop) |-> $past(level) <= $past(ft_low))
    else $error("stop released early");
  a_rts_pause: assert property (utx == U_IDLE && rts_block |=> utx == U_IDLE)
    else $error("uart started while host not ready");
  a_uart_start_bit: assert property (utx_take |=> !spi_force_strap_pin_o
    ##0 (!spi_force_strap_pin_o)[*2]) else $error("start bit missing");
  a_attn_queued: assert property (spi_selected_o && tx_valid_i |-> !attention_out_n_o)
    else $error("attention missing");
  a_miso_release: assert property (slave_select_n_i |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  a_api_on_spi: assert property (spi_selected_o |-> api_format_setting_o == API_FMT_SPI)
    else $error("spi not in api format");
  a_pkt_whole: assert property (pkt_offer_i && pkt_len_i > tx_space_i && sys_buf_full_i
    |=> pkt_drop_o && !pkt_accept_o) else $error("partial packet kept");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
// host peer model: uart partner and spi master
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic line_i,
  input wire logic miso_i,
  output logic line_o,
  output logic sclk_o,
  output logic ssel_n_o,
  output logic mosi_o
);
  // ********************
  // uart and spi drivers
  // ********************
  initial begin
    line_o = 1'b1;
    sclk_o = 1'b0;
    ssel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic bit_out(input logic v, input int div);
    @(posedge core_clk_i) line_o <= v;
    repeat (div - 1) @(posedge core_clk_i);
  endtask
  // parity bit comes from the caller, so a wrong one can be sent
  task automatic uart_send(input logic [7:0] b, input int div, input int par, input logic pb,
                           input int ns);
    bit_out(1'b0, div);
    for (int i = 0; i < 8; i++) bit_out(b[i], div);
    if (par != 0) bit_out(pb, div);
    for (int i = 0; i < ns; i++) bit_out(1'b1, div);
  endtask
  task automatic uart_recv(output logic [7:0] b, input int div, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    for (int t = 0; t < 3000 && !ok; t++) begin
      @(posedge core_clk_i);
      ok = (line_i === 1'b0);
    end
    repeat (div / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge core_clk_i);
      b[i] = line_i;
    end
    repeat (div) @(posedge core_clk_i);
    ok = ok && (line_i === 1'b1);
  endtask
  // seven link periods a half: keeps the master clock near 5 MHz
  task automatic half();
    repeat (7) @(posedge link_clk_i);
  endtask
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge link_clk_i) ssel_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      @(posedge link_clk_i) mosi_o <= tx[i];
      half();
      @(posedge link_clk_i) sclk_o <= 1'b1;
      rx[i] = miso_i;
      half();
      @(posedge link_clk_i) sclk_o <= 1'b0;
    end
    half();
    @(posedge link_clk_i) ssel_n_o <= 1'b1;
    mosi_o <= ~tx[0];
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// randomized self-checking bench for the host serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import host_serial_pkg::*;
  // ********************
  // stimulus and checks
  // ********************
  localparam int DIV = 8;
  localparam int FT = 20;
  logic core_clk_i, rst_b_i, spi_clk_i, slave_select_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
  logic attention_out_n_o, uart_rx_i, spi_force_strap_pin_i, spi_force_strap_pin_o;
  logic spi_force_strap_pin_oe_o, host_ready_n_i, module_ready_n_o, stop_bits_setting_i;
  logic uart_enable_cfg_i, spi_enable_cfg_i, host_ready_flow_enable_i, module_ready_flow_enable_i;
  logic save_config_i, store_forced_o, uart_selected_o, spi_selected_o, command_mode_o;
  logic rx_valid_o, rx_drop_o, rx_take_i, parity_error_o, tx_valid_i, tx_ready_o, status_frame_o;
  logic pkt_offer_i, sys_buf_full_i, pkt_accept_o, pkt_drop_o, link_clk, flip, strap_low, ok;
  logic stopped;
  logic [15:0] baud_setting_i;
  logic [1:0] parity_setting_i, api_format_setting_i, api_format_setting_o;
  logic [11:0] flow_stop_threshold_i, rx_level_o, pkt_len_i, tx_space_i;
  logic [2:0] pin_config_one_i, pin_config_two_i, pin_config_three_i, pin_config_four_i;
  logic [2:0] pin_config_p_two_i, pin_config_one_o, pin_config_two_o, pin_config_three_o;
  logic [2:0] pin_config_four_o, pin_config_p_two_o;
  logic [7:0] rx_data_o, tx_data_i, got, b, last_rx;
  logic [31:0] rng;
  int n_errors, cmp_count, cyc, n_rx, n_stat, n_store, lvl, n, n_drop;
  // released miso changes every cycle, so a float never reads as data
  wire logic miso_line = spi_miso_oe_o ? spi_miso_o : flip;
  assign spi_force_strap_pin_i = spi_force_strap_pin_oe_o ? spi_force_strap_pin_o : !strap_low;
  host_serial_port_select DUT (.*);
  host_model host (.core_clk_i, .link_clk_i(link_clk), .line_i(spi_force_strap_pin_i),
    .miso_i(miso_line), .line_o(uart_rx_i), .sclk_o(spi_clk_i), .ssel_n_o(slave_select_n_i),
    .mosi_o(spi_mosi_i));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  always @(posedge core_clk_i) begin
    flip <= ~flip;
    cyc <= cyc + 1;
    if (rx_valid_o === 1'b1) last_rx <= rx_data_o;
    if (rx_valid_o === 1'b1) n_rx <= n_rx + 1;
    if (status_frame_o === 1'b1) n_stat <= n_stat + 1;
    if (store_forced_o === 1'b1) n_store <= n_store + 1;
    if (rx_drop_o === 1'b1) n_drop <= n_drop + 1;
    if (cyc == 90000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic do_reset(input logic rx_low, input logic s_low, input logic u, input logic s);
    rng = xs(rng);
    @(posedge core_clk_i) rst_b_i <= 1'b0;
    host.line_o <= !rx_low;
    strap_low <= s_low;
    uart_enable_cfg_i <= u;
    spi_enable_cfg_i <= s;
    {pin_config_two_i, pin_config_three_i, pin_config_four_i, pin_config_p_two_i} <= rng[11:0];
    api_format_setting_i <= rng[13:12];
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int t = 0; t < 12 && !(s_low && attention_out_n_o === 1'b0); t++) @(posedge core_clk_i);
    host.line_o <= 1'b1;
    strap_low <= 1'b0;
    lvl = 0;
    settle(2);
  endtask
  task automatic push_tx(input logic [7:0] v);
    ok = 1'b0;
    @(posedge core_clk_i) tx_data_i <= v;
    tx_valid_i <= 1'b1;
    for (int t = 0; t < 300 && !ok; t++) begin
      @(posedge core_clk_i);
      ok = (tx_ready_o === 1'b1);
    end
    tx_valid_i <= 1'b0;
  endtask
  task automatic uart_in(input logic [7:0] v, input int par, input logic pb, input int ns);
    host.uart_send(v, DIV, par, pb, ns);
    settle(4);
  endtask
  task automatic lvl_check();
    if (lvl >= FT) stopped = 1'b1;
    else if (lvl <= FT - 17) stopped = 1'b0;
    check(16'(rx_level_o), 16'(lvl));
    check(module_ready_n_o, stopped);
  endtask
  task automatic take();
    @(posedge core_clk_i) rx_take_i <= 1'b1;
    @(posedge core_clk_i) rx_take_i <= 1'b0;
    lvl = lvl - 1;
    settle(2);
    lvl_check();
  endtask
  initial begin
    rst_b_i = 1'b0;
    {tx_valid_i, rx_take_i, save_config_i, pkt_offer_i, sys_buf_full_i, stopped} = '0;
    {host_ready_n_i, host_ready_flow_enable_i, module_ready_flow_enable_i} = '0;
    {stop_bits_setting_i, uart_enable_cfg_i, spi_enable_cfg_i, strap_low, flip} = '0;
    {tx_data_i, pkt_len_i, tx_space_i, pin_config_one_i, parity_setting_i} = '0;
    {pin_config_two_i, pin_config_three_i, pin_config_four_i, pin_config_p_two_i} = '0;
    api_format_setting_i = 2'h0;
    baud_setting_i = 16'(DIV);
    flow_stop_threshold_i = 12'(FT);
    {n_errors, cmp_count, cyc, n_rx, n_stat, n_store, lvl, n, n_drop} = '0;
    last_rx = 8'h00;
    rng = 32'd23860;
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    check(uart_selected_o, 1'b1);
    check(command_mode_o, 1'b1);
    push_tx(8'h1F);
    host.uart_recv(got, int'(BAUD_DIV_DEFAULT), ok);
    check(got, 8'h1F);
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      if (i < 2) rng[24:0] = {i == 0, 12'h0FF, 12'h100};
      @(posedge core_clk_i) pkt_offer_i <= 1'b1;
      {sys_buf_full_i, tx_space_i, pkt_len_i} <= rng[24:0];
      @(posedge core_clk_i) pkt_offer_i <= 1'b0;
      @(negedge core_clk_i);
      ok = rng[24] && (rng[11:0] > rng[23:12]);
      check(pkt_drop_o, ok);
      check(pkt_accept_o, !ok);
    end
    do_reset(1'b0, 1'b1, 1'b1, 1'b1);
    check(spi_selected_o, 1'b1);
    check(spi_force_strap_pin_oe_o, 1'b0);
    check(attention_out_n_o, 1'b0);
    check(16'(n_stat), 16'h1);
    check(api_format_setting_o, API_FMT_SPI);
    check(pin_config_one_o, PIN_FN_SPI);
    check(pin_config_p_two_o, PIN_FN_SPI);
    @(posedge core_clk_i) pin_config_one_i <= 3'h4;
    save_config_i <= 1'b1;
    @(posedge core_clk_i) save_config_i <= 1'b0;
    settle(2);
    check(pin_config_one_o, 3'h4);
    check(16'(n_store), 16'h1);
    rng = xs(rng);
    b = {rng[7:1], 1'b1};
    push_tx(b);
    settle(0);
    check(attention_out_n_o, 1'b0);
    host.spi_xfer(rng[15:8], got);
    settle(8);
    check(last_rx, rng[15:8]);
    check(spi_miso_oe_o, 1'b0);
    check(attention_out_n_o, 1'b0);
    fork
      host.spi_xfer(8'h00, got);
      begin
        settle(6);
        check(spi_miso_oe_o, 1'b1);
      end
    join
    check(got, b);
    settle(8);
    check(attention_out_n_o, 1'b1);
    host.spi_xfer(8'h00, got);
    check(got, 8'hFF);
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    check(spi_selected_o, 1'b1);
    check(16'(n_stat), 16'h1);
    check(pin_config_two_o, pin_config_two_i);
    // one byte past a full buffer: only the last is dropped
    for (int i = 0; i <= int'(RX_BUF_BYTES); i++) host.spi_xfer(8'(i), got);
    settle(8);
    check(rx_level_o, RX_BUF_BYTES);
    check(16'(n_drop), 16'h1);
    check(last_rx, 8'(RX_BUF_BYTES - 12'h1));
    do_reset(1'b0, 1'b0, 1'b1, 1'b1);
    rng = xs(rng);
    push_tx(rng[7:0]);
    host.uart_recv(got, DIV, ok);
    check(got, rng[7:0]);
    check(ok, 1'b1);
    uart_in(rng[15:8], 0, 1'b0, 1);
    lvl = 1;
    check(last_rx, rng[15:8]);
    n = n_rx;
    host.spi_xfer(8'h3C, got);
    settle(8);
    check(16'(n_rx), 16'(n));
    check(uart_selected_o, 1'b1);
    @(posedge core_clk_i) host_ready_flow_enable_i <= 1'b1;
    host_ready_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    tx_data_i <= rng[23:16];
    tx_valid_i <= 1'b1;
    settle(3);
    check(tx_ready_o, 1'b0);
    @(posedge core_clk_i) host_ready_n_i <= 1'b0;
    tx_valid_i <= 1'b0;
    push_tx(rng[23:16]);
    host.uart_recv(got, DIV, ok);
    check(got, rng[23:16]);
    @(posedge core_clk_i) module_ready_flow_enable_i <= 1'b1;
    for (int i = 0; i < FT; i++) begin
      rng = xs(rng);
      uart_in(rng[7:0], 0, 1'b0, 1);
      lvl = lvl + 1;
      lvl_check();
    end
    @(posedge core_clk_i) module_ready_flow_enable_i <= 1'b0;
    settle(0);
    check(module_ready_n_o, 1'b0);
    @(posedge core_clk_i) module_ready_flow_enable_i <= 1'b1;
    while (lvl > 0) take();
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      @(posedge core_clk_i) parity_setting_i <= (i == 1) ? PAR_ODD : PAR_EVEN;
      stop_bits_setting_i <= 1'b1;
      uart_in(rng[7:0], 1, (^rng[7:0]) ^ (i != 0), 2);
      check(parity_error_o, i == 2);
      if (i < 2) check(last_rx, rng[7:0]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
